//--- common/bcr_pkg.sv
/*
  Package for the buck converter control register bank: offsets, field positions,
  reset values, power modes and ramp timing.
  Assumes a 125 MHz clock and an APB register bus with 32-bit data.
*/
package bcr_pkg;
  // ==========================================================================
  // Register indices (byte address is four times the index)
  localparam logic [7:0] IDX_B_SLEEP_VOLT = 8'h3a;
  localparam logic [7:0] IDX_B_CONTROL = 8'h3b;
  localparam logic [7:0] IDX_B_CONTROL2 = 8'h3c;
  localparam logic [7:0] IDX_C_RUN_VOLT = 8'h3e;
  localparam logic [7:0] IDX_C_STBY_VOLT = 8'h3f;
  localparam logic [7:0] IDX_B_RUN_VOLT = 8'h38;
  localparam logic [7:0] IDX_B_STBY_VOLT = 8'h39;
  localparam logic [7:0] IDX_B_STATUS = 8'h50;
  localparam int ADDR_W = 10;
  // ==========================================================================
  // Field positions and widths
  localparam int B_VOLT_W = 6;
  localparam int C_VOLT_W = 4;
  localparam int ILIM_W = 2;
  localparam int BIT_RUN_EN = 0;
  localparam int BIT_STBY_EN = 1;
  localparam int BIT_SLEEP_EN = 2;
  localparam int BIT_LOW_POWER = 3;
  localparam int BIT_SLEW = 4;
  localparam int BIT_CCM_DOWN = 5;
  localparam int BIT_FORCED_PWM_MODE = 6;
  localparam int BIT_DIS_OFF = 7;
  localparam int BIT_TMODE = 4;
  localparam int BIT_STAT_BUSY = 8;
  localparam int BIT_STAT_EN = 9;
  // ==========================================================================
  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [1:0] ILIM_RESET = 2'h0;
  // ==========================================================================
  // Ramp timing: one code step per 2 us or per 4 us
  localparam int CLK_MHZ = 125;
  localparam int STEP_FAST_NS = 2000;
  localparam int STEP_SLOW_NS = 4000;
  localparam int STEP_FAST_CYC = STEP_FAST_NS * CLK_MHZ / 1000;
  localparam int STEP_SLOW_CYC = STEP_SLOW_NS * CLK_MHZ / 1000;
  localparam int STEP_CNT_W = 10;
  // ==========================================================================
  // Power modes
  typedef enum logic [1:0] {
    MODE_RUN = 2'b00,
    MODE_STANDBY = 2'b01,
    MODE_SLEEP = 2'b10,
    MODE_OFF = 2'b11
  } bcr_mode_t;
endpackage

//--- core/bcr_ramp.sv
/*
  Voltage ramp for the second buck: moves the applied code one step toward the
  target on every step enable, and reports a falling ramp.
  Assumes the target and step enable come from logic on the same clock.
*/
`timescale 1ns/1ps
module bcr_ramp #(
  parameter int W = 6
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic load,
  input wire logic [W-1:0] target,
  input wire logic stepEn,
  output logic [W-1:0] code,
  output logic rampDown,
  output logic busy
);
  logic [W-1:0] code_q;
  // ==========================================================================
  // Step the code toward the target
  // ramp one step
  always_ff @(posedge clk) begin
    if (reset) begin
      code_q <= '0;
    end else if (load) begin
      code_q <= target;
    end else if (stepEn && code_q < target) begin
      code_q <= code_q + W'(1);
    end else if (stepEn && code_q > target) begin
      code_q <= code_q - W'(1);
    end
  end
  assign code = code_q;
  assign busy = (code_q != target);
  assign rampDown = (code_q > target);
endmodule

//--- core/bcr_regs.sv
/*
  Control and configuration register bank for the second and third buck
  converters, an APB slave, with mode-dependent voltage and enable outputs.
  Assumes fuse values are stable while fuseLoad pulses after reset, and that
  the power mode input comes from logic on the same clock.
*/
`timescale 1ns/1ps
module bcr_regs
  import bcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic fuseLoad,
  input wire logic [B_VOLT_W-1:0] fuseBuckBRunVoltage,
  input wire logic fuseBuckBRunEnable,
  input wire logic fuseBuckARunEnable,
  input wire logic fuseBuckBSlew,
  input wire logic [ILIM_W-1:0] fuseBuckBCurrentLimit,
  input wire logic [C_VOLT_W-1:0] fuseBuckCRunVoltage,
  input wire logic [C_VOLT_W-1:0] fuseBuckCStandbyVoltage,
  input wire logic fuseBuckBRampSelect,
  input wire bcr_pkg::bcr_mode_t powerMode,
  output logic [B_VOLT_W-1:0] buckBVoltageCode,
  output logic buckBEnable,
  output logic buckBLowPower,
  output logic buckBForcedPwm,
  output logic buckBDischarge,
  output logic [ILIM_W-1:0] buckBCurrentLimitCode,
  output logic buckBTimingControlSelect,
  output logic [C_VOLT_W-1:0] buckCVoltageCode
);
  import bcr_pkg::*;

  logic [B_VOLT_W-1:0] bRunVolt_q;
  logic [B_VOLT_W-1:0] bStbyVolt_q;
  logic [B_VOLT_W-1:0] bSleepVolt_q;
  logic [7:0] bControl_q;
  logic [ILIM_W-1:0] bIlim_q;
  logic bTmode_q;
  logic [C_VOLT_W-1:0] cRunVolt_q;
  logic [C_VOLT_W-1:0] cStbyVolt_q;
  logic fuseRampSel_q;
  logic [31:0] prdata_q;
  logic [7:0] idx;
  logic aligned;
  logic wrEn;
  logic rdEn;
  logic hit;
  logic [7:0] wb;
  logic [31:0] rdMux;
  logic [B_VOLT_W-1:0] bTarget;
  logic bModeEnable;
  logic stepEn;
  logic rampDown;
  logic rampBusy;
  logic slowSel;
  logic [B_VOLT_W-1:0] rampCode;
  logic [STEP_CNT_W-1:0] stepGap_q;

  // ==========================================================================
  // APB decode: zero wait states, error on unmapped address
  assign idx = paddr[ADDR_W-1:2];
  assign aligned = (paddr[1:0] == 2'h0);
  always_comb begin
    case (idx)
      IDX_B_RUN_VOLT, IDX_B_STBY_VOLT, IDX_B_SLEEP_VOLT, IDX_B_CONTROL,
      IDX_B_CONTROL2, IDX_C_RUN_VOLT, IDX_C_STBY_VOLT, IDX_B_STATUS: hit = aligned;
      default: hit = 1'b0;
    endcase
  end
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;
  assign wrEn = psel && penable && pwrite && hit && pstrb[0];
  assign rdEn = psel && penable && !pwrite && hit;
  assign wb = pwdata[7:0];

  // ==========================================================================
  // Second buck voltage codes
  // fuse preload then writable
  always_ff @(posedge clk) begin
    if (reset) begin
      bRunVolt_q <= '0;
      bStbyVolt_q <= '0;
      bSleepVolt_q <= '0;
    end else if (fuseLoad) begin
      bRunVolt_q <= fuseBuckBRunVoltage;
      bStbyVolt_q <= fuseBuckBRunVoltage;
      bSleepVolt_q <= fuseBuckBRunVoltage;
    end else if (wrEn) begin
      if (idx == IDX_B_RUN_VOLT) begin
        bRunVolt_q <= wb[B_VOLT_W-1:0];
      end
      if (idx == IDX_B_STBY_VOLT) begin
        bStbyVolt_q <= wb[B_VOLT_W-1:0];
      end
      if (idx == IDX_B_SLEEP_VOLT) begin
        bSleepVolt_q <= wb[B_VOLT_W-1:0];
      end
    end
  end

  // ==========================================================================
  // Second buck control
  always_ff @(posedge clk) begin
    if (reset) begin
      bControl_q <= CONTROL_RESET;
    end else if (fuseLoad) begin
      bControl_q[BIT_RUN_EN] <= fuseBuckBRunEnable;
      bControl_q[BIT_STBY_EN] <= fuseBuckARunEnable;
      bControl_q[BIT_SLEW] <= fuseBuckBSlew;
    end else if (wrEn && idx == IDX_B_CONTROL) begin
      bControl_q <= wb;
    end
  end

  // ==========================================================================
  // Secondary control and fuse option
  always_ff @(posedge clk) begin
    if (reset) begin
      bIlim_q <= ILIM_RESET;
      bTmode_q <= 1'b0;
      fuseRampSel_q <= 1'b0;
    end else if (fuseLoad) begin
      bIlim_q <= fuseBuckBCurrentLimit;
      fuseRampSel_q <= fuseBuckBRampSelect;
    end else if (wrEn && idx == IDX_B_CONTROL2) begin
      bIlim_q <= wb[ILIM_W-1:0];
      bTmode_q <= wb[BIT_TMODE];
    end
  end

  // ==========================================================================
  // Third buck codes, fuse only
  // run and standby codes read-only
  always_ff @(posedge clk) begin
    if (reset) begin
      cRunVolt_q <= '0;
      cStbyVolt_q <= '0;
    end else if (fuseLoad) begin
      cRunVolt_q <= fuseBuckCRunVoltage;
      cStbyVolt_q <= fuseBuckCStandbyVoltage;
    end
  end

  // ==========================================================================
  // Read back
  // unused bits zero
  always_comb begin
    rdMux = 32'h0000_0000;
    case (idx)
      IDX_B_RUN_VOLT: rdMux[B_VOLT_W-1:0] = bRunVolt_q;
      IDX_B_STBY_VOLT: rdMux[B_VOLT_W-1:0] = bStbyVolt_q;
      IDX_B_SLEEP_VOLT: rdMux[B_VOLT_W-1:0] = bSleepVolt_q;
      IDX_B_CONTROL: rdMux[7:0] = bControl_q;
      IDX_B_CONTROL2: begin
        rdMux[ILIM_W-1:0] = bIlim_q;
        rdMux[BIT_TMODE] = bTmode_q;
      end
      IDX_C_RUN_VOLT: rdMux[C_VOLT_W-1:0] = cRunVolt_q;
      IDX_C_STBY_VOLT: rdMux[C_VOLT_W-1:0] = cStbyVolt_q;
      IDX_B_STATUS: begin
        rdMux[B_VOLT_W-1:0] = rampCode;
        rdMux[BIT_STAT_BUSY] = rampBusy;
        rdMux[BIT_STAT_EN] = buckBEnable;
      end
      default: rdMux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk) begin
    if (reset) begin
      prdata_q <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata_q <= rdMux;
    end
  end
  assign prdata = rdEn ? prdata_q : 32'h0000_0000;

  // ==========================================================================
  // Mode selection
  // mode picks code and enable
  always_comb begin
    case (powerMode)
      MODE_RUN: begin
        bTarget = bRunVolt_q;
        bModeEnable = bControl_q[BIT_RUN_EN];
      end
      MODE_STANDBY: begin
        bTarget = bStbyVolt_q;
        bModeEnable = bControl_q[BIT_STBY_EN];
      end
      MODE_SLEEP: begin
        bTarget = bSleepVolt_q;
        bModeEnable = bControl_q[BIT_SLEEP_EN];
      end
      default: begin
        bTarget = bRunVolt_q;
        bModeEnable = 1'b0;
      end
    endcase
  end

  assign slowSel = fuseRampSel_q ? 1'b1 : bControl_q[BIT_SLEW];

  bcr_step_timer u_timer (
    .clk(clk),
    .reset(reset),
    .slow(slowSel),
    .stepEn(stepEn)
  );

  bcr_ramp #(
    .W(B_VOLT_W)
  ) u_ramp (
    .clk(clk),
    .reset(reset),
    .load(fuseLoad || !buckBEnable),
    .target(bTarget),
    .stepEn(stepEn),
    .code(rampCode),
    .rampDown(rampDown),
    .busy(rampBusy)
  );

  // ==========================================================================
  // Output registers
  always_ff @(posedge clk) begin
    if (reset) begin
      buckBVoltageCode <= '0;
      buckBEnable <= 1'b0;
      buckBLowPower <= 1'b0;
      buckBForcedPwm <= 1'b0;
      buckBDischarge <= 1'b0;
      buckBCurrentLimitCode <= ILIM_RESET;
      buckBTimingControlSelect <= 1'b0;
      buckCVoltageCode <= '0;
    end else begin
      buckBVoltageCode <= rampCode;
      buckBEnable <= bModeEnable;
      buckBLowPower <= bControl_q[BIT_LOW_POWER] && (powerMode == MODE_STANDBY || powerMode == MODE_SLEEP);
      buckBForcedPwm <= bControl_q[BIT_FORCED_PWM_MODE] || (bControl_q[BIT_CCM_DOWN] && rampDown && buckBEnable);
      buckBDischarge <= !bModeEnable && !bControl_q[BIT_DIS_OFF];
      buckBCurrentLimitCode <= bIlim_q;
      buckBTimingControlSelect <= bTmode_q;
      buckCVoltageCode <= (powerMode == MODE_STANDBY || powerMode == MODE_SLEEP) ? cStbyVolt_q : cRunVolt_q;
    end
  end

  // ==========================================================================
  // Checks
  // Cycles since the last step enable, saturating
  always_ff @(posedge clk) begin
    if (reset || stepEn) begin
      stepGap_q <= '0;
    end else if (stepGap_q != '1) begin
      stepGap_q <= stepGap_q + STEP_CNT_W'(1);
    end
  end
  sequence wr_ctrl_s;
    psel && penable && pwrite && pstrb[0] && paddr == {IDX_B_CONTROL, 2'b00} && !fuseLoad;
  endsequence
  sequence wr_ilim_s;
    psel && penable && pwrite && pstrb[0] && paddr == {IDX_B_CONTROL2, 2'b00} && !fuseLoad;
  endsequence
  ctrl_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_ctrl_s |=> bControl_q == $past(pwdata[7:0])) else $error("control write not stored");
  c_readonly_a: assert property (@(posedge clk) disable iff (reset)
    !fuseLoad |=> $stable(cRunVolt_q) && $stable(cStbyVolt_q)) else $error("third buck code changed");
  low_power_a: assert property (@(posedge clk) disable iff (reset)
    powerMode == MODE_RUN |=> !buckBLowPower) else $error("low power in run mode");
  discharge_a: assert property (@(posedge clk) disable iff (reset)
    bModeEnable |=> !buckBDischarge) else $error("discharge while enabled");
  forced_pwm_mode_force_a: assert property (@(posedge clk) disable iff (reset)
    bControl_q[BIT_FORCED_PWM_MODE] |=> buckBForcedPwm) else $error("forced pwm missing");
  slew_sel_a: assert property (@(posedge clk) disable iff (reset)
    stepEn && fuseRampSel_q |-> stepGap_q >= STEP_CNT_W'(STEP_SLOW_CYC - 1))
    else $error("fuse option ignored");
  ilim_out_a: assert property (@(posedge clk) disable iff (reset)
    1'b1 |=> buckBCurrentLimitCode == $past(bIlim_q)) else $error("current limit not applied");
  fuse_load_a: assert property (@(posedge clk) disable iff (reset)
    fuseLoad |=> bSleepVolt_q == $past(fuseBuckBRunVoltage) && bIlim_q == $past(fuseBuckBCurrentLimit))
    else $error("fuse preload missing");
  unused_zero_a: assert property (@(posedge clk) disable iff (reset)
    rdEn && idx == IDX_C_RUN_VOLT |-> prdata[31:C_VOLT_W] == '0) else $error("unused bits not zero");
  ilim_write_a: assert property (@(posedge clk) disable iff (reset)
    wr_ilim_s |=> bIlim_q == $past(pwdata[ILIM_W-1:0]))
    else $error("current limit write not stored");
  fuse_ctrl_a: assert property (@(posedge clk) disable iff (reset)
    fuseLoad |=> bControl_q[BIT_STBY_EN] == $past(fuseBuckARunEnable))
    else $error("standby enable preload missing");
  run_enable_a: assert property (@(posedge clk) disable iff (reset)
    powerMode == MODE_RUN |=> buckBEnable == $past(bControl_q[BIT_RUN_EN]))
    else $error("run enable not applied");
  stby_enable_a: assert property (@(posedge clk) disable iff (reset)
    powerMode == MODE_STANDBY |=> buckBEnable == $past(bControl_q[BIT_STBY_EN]))
    else $error("standby enable not applied");
  sleep_enable_a: assert property (@(posedge clk) disable iff (reset)
    powerMode == MODE_SLEEP |=> buckBEnable == $past(bControl_q[BIT_SLEEP_EN]))
    else $error("sleep enable not applied");
  lp_sleep_a: assert property (@(posedge clk) disable iff (reset)
    bControl_q[BIT_LOW_POWER] && powerMode == MODE_SLEEP |=> buckBLowPower)
    else $error("low power missing in sleep");
  ccm_down_a: assert property (@(posedge clk) disable iff (reset)
    bControl_q[BIT_CCM_DOWN] && rampDown && buckBEnable |=> buckBForcedPwm)
    else $error("ccm missing on falling ramp");
  discharge_on_a: assert property (@(posedge clk) disable iff (reset)
    !bModeEnable && !bControl_q[BIT_DIS_OFF] |=> buckBDischarge)
    else $error("discharge missing while off");
  ramp_hold_a: assert property (@(posedge clk) disable iff (reset)
    buckBEnable && !fuseLoad && !stepEn |=> $stable(rampCode))
    else $error("ramp moved without step");
  ramp_step_a: assert property (@(posedge clk) disable iff (reset)
    buckBEnable && !fuseLoad && stepEn && rampBusy |=> rampCode != $past(rampCode))
    else $error("ramp step missed");
  c_stby_code_a: assert property (@(posedge clk) disable iff (reset)
    powerMode == MODE_STANDBY || powerMode == MODE_SLEEP |=> buckCVoltageCode == $past(cStbyVolt_q))
    else $error("third buck standby code not applied");
  c_run_code_a: assert property (@(posedge clk) disable iff (reset)
    powerMode == MODE_RUN || powerMode == MODE_OFF |=> buckCVoltageCode == $past(cRunVolt_q))
    else $error("third buck run code not applied");
endmodule

//--- core/bcr_step_timer.sv
/*
  Step timer: one-cycle enable pulse every 2 us or every 4 us.
  Assumes a single clock; the slow select may change at any time.
*/
`timescale 1ns/1ps
module bcr_step_timer
  import bcr_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic slow,
  output logic stepEn
);
  logic [STEP_CNT_W-1:0] cnt_q;
  logic [STEP_CNT_W-1:0] limit;
  // ==========================================================================
  // Divider
  // step period select
  assign limit = slow ? STEP_CNT_W'(STEP_SLOW_CYC - 1) : STEP_CNT_W'(STEP_FAST_CYC - 1);
  always_ff @(posedge clk) begin
    if (reset || cnt_q >= limit) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + STEP_CNT_W'(1);
    end
  end
  assign stepEn = (cnt_q == limit);
endmodule

//--- verification/buck_converter_control_regs_tb.sv
/*
  Self-checking testbench for the buck converter control register bank.
  Assumes the bcr_pkg package and bcr_regs are compiled first, zero-wait APB.
*/
`timescale 1ns/1ps
module buck_converter_control_regs_tb;
  import bcr_pkg::*;
  // ==========================================================================
  // Signals
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic fuseLoad = 1'b0;
  logic [B_VOLT_W-1:0] fuseBuckBRunVoltage = 6'h20;
  logic fuseBuckBRunEnable = 1'b1;
  logic fuseBuckARunEnable = 1'b1;
  logic fuseBuckBSlew = 1'b0;
  logic [ILIM_W-1:0] fuseBuckBCurrentLimit = 2'h2;
  logic [C_VOLT_W-1:0] fuseBuckCRunVoltage = 4'h9;
  logic [C_VOLT_W-1:0] fuseBuckCStandbyVoltage = 4'h5;
  logic fuseBuckBRampSelect = 1'b0;
  bcr_mode_t powerMode = MODE_RUN;
  logic [B_VOLT_W-1:0] buckBVoltageCode;
  logic buckBEnable;
  logic buckBLowPower;
  logic buckBForcedPwm;
  logic buckBDischarge;
  logic [ILIM_W-1:0] buckBCurrentLimitCode;
  logic buckBTimingControlSelect;
  logic [C_VOLT_W-1:0] buckCVoltageCode;
  int miscompares = 0;
  int totalChecks = 0;

  always #4 clk = ~clk;

  bcr_regs u_bcr_regs (
    .clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fuseLoad(fuseLoad), .fuseBuckBRunVoltage(fuseBuckBRunVoltage),
    .fuseBuckBRunEnable(fuseBuckBRunEnable), .fuseBuckARunEnable(fuseBuckARunEnable),
    .fuseBuckBSlew(fuseBuckBSlew), .fuseBuckBCurrentLimit(fuseBuckBCurrentLimit),
    .fuseBuckCRunVoltage(fuseBuckCRunVoltage), .fuseBuckCStandbyVoltage(fuseBuckCStandbyVoltage),
    .fuseBuckBRampSelect(fuseBuckBRampSelect), .powerMode(powerMode),
    .buckBVoltageCode(buckBVoltageCode), .buckBEnable(buckBEnable), .buckBLowPower(buckBLowPower),
    .buckBForcedPwm(buckBForcedPwm), .buckBDischarge(buckBDischarge),
    .buckBCurrentLimitCode(buckBCurrentLimitCode), .buckBTimingControlSelect(buckBTimingControlSelect),
    .buckCVoltageCode(buckCVoltageCode)
  );

  // ==========================================================================
  // Shared tasks
  task automatic close_out;
    $display("Checks %0d, mismatches %0d", totalChecks, miscompares);
    if (miscompares == 0 && totalChecks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask

  task automatic apb(input logic [7:0] idx, input logic wr, input logic [31:0] wd, input logic [3:0] st,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      chk(pready, 1'b1);
      close_out();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] v, input logic [3:0] st = 4'hf);
    logic [31:0] rd;
    logic err;
    apb(idx, 1'b1, {24'h0, v}, st, rd, err);
  endtask

  task automatic rdc(input logic [7:0] idx, input logic [31:0] exp, input logic expErr = 1'b0);
    logic [31:0] rd;
    logic err;
    apb(idx, 1'b0, 32'h0, 4'h0, rd, err);
    chk(err, expErr);
    if (!expErr) chk(rd, exp);
  endtask

  task automatic outs(input bcr_mode_t m, input logic [3:0] exp, input logic [3:0] expC);
    powerMode <= m;
    repeat (3) @(posedge clk);
    chk({buckBEnable, buckBLowPower, buckBForcedPwm, buckBDischarge}, exp);
    chk(buckCVoltageCode, expC);
  endtask

  task automatic ramp(input bcr_mode_t m, input logic [5:0] tgt, input int cyc, input logic pwmMid);
    int n;
    powerMode <= m;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      if (n == 10) chk(buckBForcedPwm, pwmMid);
    end while (buckBVoltageCode !== tgt && n < 2 * cyc + 20);
    chk(n >= cyc && n <= 2 * cyc + 4, 1'b1);
    if (buckBVoltageCode !== tgt) close_out();
  endtask

  task automatic fuse_pulse;
    @(posedge clk);
    fuseLoad <= 1'b1;
    @(posedge clk);
    fuseLoad <= 1'b0;
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset_values;
    rdc(IDX_B_CONTROL, 32'h00);
    rdc(IDX_B_CONTROL2, 32'h00);
  endtask

  task automatic t_fuse_load;
    fuse_pulse();
    rdc(IDX_B_SLEEP_VOLT, 32'h20);
    rdc(IDX_B_CONTROL, 32'h03);
    rdc(IDX_B_CONTROL2, 32'h02);
    rdc(IDX_C_RUN_VOLT, 32'h09);
    rdc(IDX_C_STBY_VOLT, 32'h05);
  endtask

  task automatic t_access;
    wr(IDX_B_SLEEP_VOLT, 8'hff);
    rdc(IDX_B_SLEEP_VOLT, 32'h3f);
    wr(IDX_B_CONTROL2, 8'hff);
    rdc(IDX_B_CONTROL2, 32'h13);
    wr(IDX_C_RUN_VOLT, 8'hff);
    wr(IDX_C_STBY_VOLT, 8'h00);
    rdc(IDX_C_RUN_VOLT, 32'h09);
    rdc(IDX_C_STBY_VOLT, 32'h05);
    wr(IDX_B_CONTROL, 8'hff, 4'he);
    rdc(IDX_B_CONTROL, 32'h03);
    rdc(8'h3d, 32'h0, 1'b1);
    chk({buckBCurrentLimitCode, buckBTimingControlSelect}, 3'h7);
  endtask

  task automatic t_outputs;
    outs(MODE_RUN, 4'b1000, 4'h9);
    wr(IDX_B_CONTROL, 8'h48);
    outs(MODE_RUN, 4'b0011, 4'h9);
    outs(MODE_STANDBY, 4'b0111, 4'h5);
    wr(IDX_B_CONTROL, 8'hc8);
    outs(MODE_SLEEP, 4'b0110, 4'h5);
    wr(IDX_B_CONTROL, 8'h0c);
    outs(MODE_SLEEP, 4'b1100, 4'h5);
    outs(MODE_OFF, 4'b0001, 4'h9);
  endtask

  task automatic t_ramps;
    wr(IDX_B_CONTROL, 8'h25);
    wr(IDX_B_SLEEP_VOLT, 8'h1e);
    outs(MODE_RUN, 4'b1000, 4'h9);
    ramp(MODE_SLEEP, 6'h1e, STEP_FAST_CYC, 1'b1);
    wr(IDX_B_CONTROL, 8'h35);
    ramp(MODE_RUN, 6'h20, STEP_SLOW_CYC, 1'b0);
    fuseBuckBRampSelect <= 1'b1;
    fuse_pulse();
    wr(IDX_B_CONTROL, 8'h05);
    wr(IDX_B_SLEEP_VOLT, 8'h1e);
    ramp(MODE_SLEEP, 6'h1e, STEP_SLOW_CYC, 1'b0);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_reset_values();
    t_fuse_load();
    t_access();
    t_outputs();
    t_ramps();
    close_out();
  end
endmodule
